// ===== verilog/prc_map.svh
/*
  command codes, reset values, field positions and timing counts
  for the rail command decoder; assumes a 50 MHz core clock.
*/
`ifndef PRC_MAP_SVH
`define PRC_MAP_SVH

`define PRC_CHSEL 8'h00
`define PRC_RUNCTL 8'h01
`define PRC_ONCFG 8'h02
`define PRC_FCLR 8'h03
`define PRC_SAVE 8'h15
`define PRC_LOAD 8'h16
`define PRC_OFMT 8'h20
`define PRC_VTGT 8'h21
`define PRC_VTRIM 8'h23
`define PRC_VMAX 8'h24
`define PRC_MUP 8'h25
`define PRC_MDN 8'h26
`define PRC_SLEW 8'h27
`define PRC_DROOP 8'h28
`define PRC_FSW 8'h33
`define PRC_PHASE 8'h37
`define PRC_IGAIN 8'h38
`define PRC_ITRIM 8'h39
`define PRC_VOVF 8'h40
`define PRC_VOVA 8'h41
`define PRC_VOVW 8'h42
`define PRC_VUVW 8'h43
`define PRC_VUVF 8'h44
`define PRC_VUVA 8'h45
`define PRC_OCF 8'h46
`define PRC_OCW 8'h4A
`define PRC_UCF 8'h4B
`define PRC_OTF 8'h4F
`define PRC_OTA 8'h50
`define PRC_OTW 8'h51
`define PRC_UTW 8'h52
`define PRC_UTF 8'h53
`define PRC_UTA 8'h54
`define PRC_VINOVF 8'h55
`define PRC_VINOVA 8'h56
`define PRC_VINOVW 8'h57
`define PRC_VINUVW 8'h58

`define PRC_CHSEL_RST 8'h00
`define PRC_CH_ONE 8'h01
`define PRC_CH_BOTH 8'hFF
`define PRC_RUNCTL_RST 16'h0000
`define PRC_ONCFG_RST 16'h0017
`define PRC_OFMT_VAL 16'h0013
`define PRC_ZERO 16'h0000
`define PRC_SLEW_RST 16'hBA00
`define PRC_ACT_RST 16'h0080
`define PRC_OCF_RST 16'hE320
`define PRC_OCW_RST 16'h0000
`define PRC_UCF_RST 16'hE4E0
`define PRC_OTF_RST 16'hEB98
`define PRC_OTW_RST 16'hEB48
`define PRC_UTW_RST 16'hDC40
`define PRC_UTF_RST 16'hE530
`define PRC_VINOVF_RST 16'hD3A0
`define PRC_VINOVW_RST 16'hD353
`define PRC_VINUVW_RST 16'h0000
`define PRC_PH0_RST 16'h0021
`define PRC_PH1_RST 16'h0022
`define PRC_IG0_RST 16'hB2C3
`define PRC_IG1_RST 16'hB2D7
`define PRC_IT0_RST 16'hB529
`define PRC_IT1_RST 16'hBDDC

`define PRC_PCT_MAX 8'd110
`define PRC_PCT_MUP 8'd105
`define PRC_PCT_MDN 8'd95
`define PRC_PCT_OVF 8'd115
`define PRC_PCT_OVW 8'd110
`define PRC_PCT_UVW 8'd90
`define PRC_PCT_UVF 8'd85
`define PRC_PCT_ONE 24'd100

`define PRC_ON_BIT 7
`define PRC_MRG_HI_BIT 5
`define PRC_MRG_LO_BIT 4
`define PRC_CFG_USE 4
`define PRC_CFG_OP 3
`define PRC_CFG_PIN 2
`define PRC_CFG_POL 1
`define PRC_ACT_HI 7
`define PRC_ACT_LO 6
`define PRC_DROP_SH 19

`define PRC_CLK_HZ 50000000
`define PRC_MS_CYC (`PRC_CLK_HZ / 1000)
`define PRC_SLEW_THR 48'(8 * `PRC_MS_CYC)

`endif

// ===== verilog/prc_pkg.sv
/*
  types shared by the rail command decoder.
  assumes prc_map.svh supplies the numeric constants.
*/
package prc_pkg;
  typedef enum logic [2:0] {
    PRC_K_NONE,
    PRC_K_BYTE,
    PRC_K_WORD,
    PRC_K_RO,
    PRC_K_SEND,
    PRC_K_SEL
  } prc_kind_t;

  typedef enum logic {
    PRC_ST_INIT,
    PRC_ST_RUN
  } prc_state_t;
endpackage

// ===== verilog/prc_core.sv
/*
  command decoder and settings store for a two-rail step-down module.
  assumes a framed command port from the bus front end, measurements
  already in the documented word formats, straps stable at reset release.
*/
// How it works
// - channel selector at 00h, resets to first
// - 01h byte sets on, off, margin modes
// - 02h picks pin or command control, 17h
// - 15h copies working settings into storage
// - 16h reloads working settings from storage
// - 20h reads fixed 13h, writes refused
// - 21h nominal voltage, strap sets default
// - 23h signed trim added, resets zero
// - 24h clamps target, default 110 percent
// - margin targets 25h/26h, 105/95 percent
// - slew rate from 27h, resets BA00h
// - droop slope 28h, resets zero
// - 33h switching rate, strap sets default
// - 37h phase offset, 0021h/0022h defaults
// - 38h sense gain, per-channel defaults
// - 40h overvoltage fault, action 41h
// - 42h/43h output voltage warnings
// - 44h undervoltage fault, action 45h
// - 46h peak fault, 4Ah average warning
// - 4Bh valley current fault, E4E0h
// - temperature limits, actions 50h/54h
// - input voltage fault 55h, warnings
`timescale 1ns/1ps
`include "prc_map.svh"

module prc_core (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic [1:0] en_pin,
  input wire logic [15:0] strap_vout,
  input wire logic [15:0] strap_freq,
  input wire logic [31:0] meas_vout,
  input wire logic [31:0] meas_ipeak,
  input wire logic [31:0] meas_ivalley,
  input wire logic [31:0] meas_iavg,
  input wire logic [31:0] meas_temp,
  input wire logic [15:0] meas_vin,
  output logic rsp_valid,
  output logic rsp_err,
  output logic [15:0] rsp_data,
  output logic [1:0] rail_on,
  output logic [31:0] vout_ref,
  output logic [13:0] fault_flags,
  output logic [13:0] warn_flags,
  output logic [31:0] switch_rate,
  output logic [31:0] phase_offset,
  output logic [31:0] isense_gain,
  output logic [31:0] isense_trim
);

  function automatic prc_pkg::prc_kind_t reg_kind(input logic [7:0] k);
    if (k == `PRC_CHSEL) begin
      reg_kind = prc_pkg::PRC_K_SEL;
    end else if (k == `PRC_FCLR || k == `PRC_SAVE || k == `PRC_LOAD) begin
      reg_kind = prc_pkg::PRC_K_SEND;
    end else if (k == `PRC_OFMT) begin
      reg_kind = prc_pkg::PRC_K_RO;
    end else if (k == `PRC_RUNCTL || k == `PRC_ONCFG || k == `PRC_VOVA ||
                 k == `PRC_VUVA || k == `PRC_OTA || k == `PRC_UTA ||
                 k == `PRC_VINOVA) begin
      reg_kind = prc_pkg::PRC_K_BYTE;
    end else if (k == `PRC_VTGT || (k >= `PRC_VTRIM && k <= `PRC_DROOP) ||
                 k == `PRC_FSW || (k >= `PRC_PHASE && k <= `PRC_ITRIM) ||
                 k == `PRC_VOVF || (k >= `PRC_VOVW && k <= `PRC_VUVF) ||
                 k == `PRC_OCF || k == `PRC_OCW || k == `PRC_UCF ||
                 k == `PRC_OTF || (k >= `PRC_OTW && k <= `PRC_UTF) ||
                 k == `PRC_VINOVF || k == `PRC_VINOVW ||
                 k == `PRC_VINUVW) begin
      reg_kind = prc_pkg::PRC_K_WORD;
    end else begin
      reg_kind = prc_pkg::PRC_K_NONE;
    end
  endfunction

  function automatic logic [7:0] idx(input logic ch, input logic [7:0] k);
    idx = {ch, k[6:0]};
  endfunction

  // selector byte to a per-rail mask; unknown codes select nothing
  function automatic logic [1:0] sel_of(input logic [7:0] v);
    if (v == `PRC_CHSEL_RST) begin
      sel_of = 2'b01;
    end else if (v == `PRC_CH_ONE) begin
      sel_of = 2'b10;
    end else if (v == `PRC_CH_BOTH) begin
      sel_of = 2'b11;
    end else begin
      sel_of = 2'b00;
    end
  endfunction

  function automatic logic [15:0] pct(input logic [15:0] v, input logic [7:0] p);
    logic [23:0] t;
    t = {8'h00, v} * {16'h0000, p};
    pct = 16'(t / `PRC_PCT_ONE);
  endfunction

  // mantissa scaled to 2^-16 units; exponent plus 16 is the top bit flipped
  function automatic logic signed [47:0] l11_fix(input logic [15:0] w);
    logic signed [47:0] m;
    logic [4:0] sh;
    m = {{37{w[10]}}, w[10:0]};
    sh = {~w[15], w[14:11]};
    l11_fix = m <<< sh;
  endfunction

  function automatic logic [15:0] dflt(input logic [7:0] k, input logic ch,
                                       input logic [15:0] sv,
                                       input logic [15:0] sf);
    case (k)
      `PRC_RUNCTL: dflt = `PRC_RUNCTL_RST;
      `PRC_ONCFG: dflt = `PRC_ONCFG_RST;
      `PRC_OFMT: dflt = `PRC_OFMT_VAL;
      `PRC_VTGT: dflt = sv;
      `PRC_VTRIM: dflt = `PRC_ZERO;
      `PRC_VMAX: dflt = pct(sv, `PRC_PCT_MAX);
      `PRC_MUP: dflt = pct(sv, `PRC_PCT_MUP);
      `PRC_MDN: dflt = pct(sv, `PRC_PCT_MDN);
      `PRC_SLEW: dflt = `PRC_SLEW_RST;
      `PRC_DROOP: dflt = `PRC_ZERO;
      `PRC_FSW: dflt = sf;
      `PRC_PHASE: dflt = ch ? `PRC_PH1_RST : `PRC_PH0_RST;
      `PRC_IGAIN: dflt = ch ? `PRC_IG1_RST : `PRC_IG0_RST;
      `PRC_ITRIM: dflt = ch ? `PRC_IT1_RST : `PRC_IT0_RST;
      `PRC_VOVF: dflt = pct(sv, `PRC_PCT_OVF);
      `PRC_VOVW: dflt = pct(sv, `PRC_PCT_OVW);
      `PRC_VUVW: dflt = pct(sv, `PRC_PCT_UVW);
      `PRC_VUVF: dflt = pct(sv, `PRC_PCT_UVF);
      `PRC_VOVA, `PRC_VUVA, `PRC_OTA, `PRC_UTA, `PRC_VINOVA: dflt = `PRC_ACT_RST;
      `PRC_OCF: dflt = `PRC_OCF_RST;
      `PRC_OCW: dflt = `PRC_OCW_RST;
      `PRC_UCF: dflt = `PRC_UCF_RST;
      `PRC_OTF: dflt = `PRC_OTF_RST;
      `PRC_OTW: dflt = `PRC_OTW_RST;
      `PRC_UTW: dflt = `PRC_UTW_RST;
      `PRC_UTF: dflt = `PRC_UTF_RST;
      `PRC_VINOVF: dflt = `PRC_VINOVF_RST;
      `PRC_VINOVW: dflt = `PRC_VINOVW_RST;
      `PRC_VINUVW: dflt = `PRC_VINUVW_RST;
      default: dflt = `PRC_ZERO;
    endcase
  endfunction

  prc_pkg::prc_state_t state;
  prc_pkg::prc_kind_t kind;
  logic [7:0] chsel;
  logic [15:0] wk [0:255];
  logic [15:0] nv [0:255];
  logic [1:0] sel;
  logic rd_ch;
  logic next_rsp_err;
  logic [15:0] next_rsp_data;
  logic taken;
  logic do_wr;
  logic do_clr;
  logic do_save;
  logic do_load;

  always_comb begin
    kind = reg_kind(cmd_code);
    sel = sel_of(chsel);
    rd_ch = sel == 2'b10; // both-channel reads answer from the first
  end

  always_comb begin
    next_rsp_data = `PRC_ZERO;
    next_rsp_err = 1'b0;
    if (state == prc_pkg::PRC_ST_INIT || kind == prc_pkg::PRC_K_NONE) begin
      next_rsp_err = 1'b1;
    end else if (kind == prc_pkg::PRC_K_SEL) begin
      // a selector that would select nothing is refused, not stored
      if (cmd_write && sel_of(cmd_wdata[7:0]) == 2'b00) begin
        next_rsp_err = 1'b1;
      end else if (!cmd_write) begin
        next_rsp_data = {8'h00, chsel};
      end
    end else if (sel == 2'b00) begin
      next_rsp_err = 1'b1;
    end else if (cmd_write && kind == prc_pkg::PRC_K_RO) begin
      next_rsp_err = 1'b1;
    end else if (!cmd_write && kind == prc_pkg::PRC_K_SEND) begin
      next_rsp_err = 1'b1;
    end else if (!cmd_write) begin
      next_rsp_data = wk[idx(rd_ch, cmd_code)];
    end
  end

  assign taken = cmd_valid && !next_rsp_err;
  assign do_wr = taken && cmd_write;
  assign do_clr = do_wr && cmd_code == `PRC_FCLR;
  assign do_save = do_wr && cmd_code == `PRC_SAVE;
  assign do_load = do_wr && cmd_code == `PRC_LOAD;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_err <= 1'b0;
      rsp_data <= `PRC_ZERO;
    end else begin
      rsp_valid <= cmd_valid;
      rsp_err <= cmd_valid && next_rsp_err;
      rsp_data <= cmd_valid ? next_rsp_data : `PRC_ZERO;
    end
  end

  // straps are caught on the first edge after release; storage also samples them on each edge under reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= prc_pkg::PRC_ST_INIT;
    end else begin
      case (state)
        prc_pkg::PRC_ST_INIT: state <= prc_pkg::PRC_ST_RUN;
        default: state <= prc_pkg::PRC_ST_RUN;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      chsel <= `PRC_CHSEL_RST;
    end else if (do_wr && kind == prc_pkg::PRC_K_SEL) begin
      chsel <= cmd_wdata[7:0];
    end
  end

  // storage has no reset: it is loaded with defaults in the init cycle
  always_ff @(posedge core_clk) begin
    if (state == prc_pkg::PRC_ST_INIT) begin
      for (int i = 0; i < 256; i++) begin
        nv[i] <= dflt({1'b0, 7'(i)}, i[7], strap_vout, strap_freq);
      end
    end else if (do_save) begin
      for (int i = 0; i < 256; i++) begin
        nv[i] <= wk[i];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 256; i++) begin
        wk[i] <= `PRC_ZERO;
      end
    end else if (state == prc_pkg::PRC_ST_INIT) begin
      for (int i = 0; i < 256; i++) begin
        wk[i] <= dflt({1'b0, 7'(i)}, i[7], strap_vout, strap_freq);
      end
    end else if (do_load) begin
      for (int i = 0; i < 256; i++) begin
        wk[i] <= nv[i];
      end
    end else if (do_wr && (kind == prc_pkg::PRC_K_BYTE || kind == prc_pkg::PRC_K_WORD)) begin
      for (int c = 0; c < 2; c++) begin
        if (sel[c]) begin
          // byte settings keep only the low lane
          wk[idx(c[0], cmd_code)] <= (kind == prc_pkg::PRC_K_BYTE) ?
              {8'h00, cmd_wdata[7:0]} : cmd_wdata;
        end
      end
    end
  end

  logic signed [47:0] vin_fix;
  assign vin_fix = l11_fix(meas_vin);

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [15:0] op;
    logic [15:0] cfg;
    logic [15:0] vo;
    logic [15:0] tgt;
    logic [15:0] base;
    logic signed [16:0] sum;
    logic signed [47:0] rate;
    logic [47:0] acc;
    logic [47:0] acc_sum;
    logic [15:0] ramp;
    logic signed [95:0] drop;
    logic [6:0] hit;
    logic [6:0] whit;
    logic [6:0] flt;
    logic [6:0] wrn;
    logic act;
    logic shut;
    logic req;
    logic on_q;
    logic [15:0] vref_q;
    logic [15:0] fsw_q;
    logic [15:0] ph_q;
    logic [15:0] ig_q;
    logic [15:0] it_q;

    always_comb begin
      op = wk[idx(c[0], `PRC_RUNCTL)];
      cfg = wk[idx(c[0], `PRC_ONCFG)];
      vo = meas_vout[16*c +: 16];
      // pin polarity compared only when the pin is required
      req = !cfg[`PRC_CFG_USE] ||
            ((!cfg[`PRC_CFG_OP] || op[`PRC_ON_BIT]) &&
             (!cfg[`PRC_CFG_PIN] || en_pin[c] == cfg[`PRC_CFG_POL]));
      if (op[`PRC_MRG_HI_BIT] && !op[`PRC_MRG_LO_BIT]) begin
        base = wk[idx(c[0], `PRC_MUP)];
      end else if (op[`PRC_MRG_LO_BIT] && !op[`PRC_MRG_HI_BIT]) begin
        base = wk[idx(c[0], `PRC_MDN)];
      end else begin
        base = wk[idx(c[0], `PRC_VTGT)];
      end
      sum = $signed({1'b0, base}) + $signed({wk[idx(c[0], `PRC_VTRIM)][15],
                                             wk[idx(c[0], `PRC_VTRIM)]});
      if (sum < 0) begin
        tgt = `PRC_ZERO;
      end else if (sum[15:0] > wk[idx(c[0], `PRC_VMAX)]) begin
        tgt = wk[idx(c[0], `PRC_VMAX)];
      end else begin
        tgt = sum[15:0];
      end
      rate = l11_fix(wk[idx(c[0], `PRC_SLEW)]);
      acc_sum = acc + ((rate < 0) ? 48'h0 : rate);
      drop = (l11_fix(wk[idx(c[0], `PRC_DROOP)]) * l11_fix(meas_iavg[16*c +: 16]))
             >>> `PRC_DROP_SH;
    end

    always_comb begin
      hit[0] = vo > wk[idx(c[0], `PRC_VOVF)];
      hit[1] = on_q && vo < wk[idx(c[0], `PRC_VUVF)];
      hit[2] = l11_fix(meas_ipeak[16*c +: 16]) >
               l11_fix(wk[idx(c[0], `PRC_OCF)]);
      hit[3] = l11_fix(meas_ivalley[16*c +: 16]) <
               l11_fix(wk[idx(c[0], `PRC_UCF)]);
      hit[4] = l11_fix(meas_temp[16*c +: 16]) > l11_fix(wk[idx(c[0], `PRC_OTF)]);
      hit[5] = l11_fix(meas_temp[16*c +: 16]) < l11_fix(wk[idx(c[0], `PRC_UTF)]);
      hit[6] = vin_fix > l11_fix(wk[idx(c[0], `PRC_VINOVF)]);
      whit[0] = vo > wk[idx(c[0], `PRC_VOVW)];
      whit[1] = on_q && vo < wk[idx(c[0], `PRC_VUVW)];
      whit[2] = l11_fix(meas_iavg[16*c +: 16]) > l11_fix(wk[idx(c[0], `PRC_OCW)]);
      whit[3] = l11_fix(meas_temp[16*c +: 16]) > l11_fix(wk[idx(c[0], `PRC_OTW)]);
      whit[4] = l11_fix(meas_temp[16*c +: 16]) < l11_fix(wk[idx(c[0], `PRC_UTW)]);
      whit[5] = vin_fix > l11_fix(wk[idx(c[0], `PRC_VINOVW)]);
      whit[6] = vin_fix < l11_fix(wk[idx(c[0], `PRC_VINUVW)]);
      // any response code other than ignore shuts the rail down
      act = (hit[0] && wk[idx(c[0], `PRC_VOVA)][`PRC_ACT_HI:`PRC_ACT_LO] != 2'b00) ||
            (hit[1] && wk[idx(c[0], `PRC_VUVA)][`PRC_ACT_HI:`PRC_ACT_LO] != 2'b00) ||
            (hit[4] && wk[idx(c[0], `PRC_OTA)][`PRC_ACT_HI:`PRC_ACT_LO] != 2'b00) ||
            (hit[5] && wk[idx(c[0], `PRC_UTA)][`PRC_ACT_HI:`PRC_ACT_LO] != 2'b00) ||
            (hit[6] && wk[idx(c[0], `PRC_VINOVA)][`PRC_ACT_HI:`PRC_ACT_LO] != 2'b00);
    end

    // sticky: a new hit in the clear cycle survives
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        flt <= 7'h00;
        wrn <= 7'h00;
      end else if (state == prc_pkg::PRC_ST_RUN) begin
        flt <= (flt & {7{!do_clr}}) | hit;
        wrn <= (wrn & {7{!do_clr}}) | whit;
      end
    end

    // no retry: latched off until faults are cleared or the rail is dropped
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        shut <= 1'b0;
        on_q <= 1'b0;
      end else if (state == prc_pkg::PRC_ST_RUN) begin
        shut <= act || (shut && !do_clr && req);
        on_q <= req && !shut && !act;
      end
    end

    // one step per cycle at most; remainder is dropped, a small rate error
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        acc <= 48'h0;
        ramp <= `PRC_ZERO;
      end else if (!on_q) begin
        acc <= 48'h0;
        ramp <= `PRC_ZERO;
      end else if (ramp == tgt) begin
        acc <= 48'h0;
      end else if (acc_sum >= `PRC_SLEW_THR) begin
        acc <= 48'h0;
        ramp <= (ramp < tgt) ? ramp + 16'h0001 : ramp - 16'h0001;
      end else begin
        acc <= acc_sum;
      end
    end

    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        vref_q <= `PRC_ZERO;
        fsw_q <= `PRC_ZERO;
        ph_q <= `PRC_ZERO;
        ig_q <= `PRC_ZERO;
        it_q <= `PRC_ZERO;
      end else begin
        if (drop <= 0) begin
          vref_q <= ramp;
        end else if (drop >= $signed({80'h0, ramp})) begin
          vref_q <= `PRC_ZERO;
        end else begin
          vref_q <= ramp - drop[15:0];
        end
        fsw_q <= wk[idx(c[0], `PRC_FSW)];
        ph_q <= wk[idx(c[0], `PRC_PHASE)];
        ig_q <= wk[idx(c[0], `PRC_IGAIN)];
        it_q <= wk[idx(c[0], `PRC_ITRIM)];
      end
    end

    assign rail_on[c] = on_q;
    assign vout_ref[16*c +: 16] = vref_q;
    assign fault_flags[7*c +: 7] = flt;
    assign warn_flags[7*c +: 7] = wrn;
    assign switch_rate[16*c +: 16] = fsw_q;
    assign phase_offset[16*c +: 16] = ph_q;
    assign isense_gain[16*c +: 16] = ig_q;
    assign isense_trim[16*c +: 16] = it_q;
  end

endmodule

// ===== dv/prc_core_props.sv
/*
  assertion checker on the command decoder ports.
  assumes one clock domain and the asynchronous active-high reset.
*/
`timescale 1ns/1ps

module prc_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic [15:0] rsp_data,
  input wire logic [1:0] rail_on,
  input wire logic [31:0] vout_ref,
  input wire logic [13:0] fault_flags,
  input wire logic [13:0] warn_flags
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  logic clr;
  assign clr = cmd_valid && cmd_write && cmd_code == 8'h03;

  property p_answer;
    cmd_valid |=> rsp_valid;
  endproperty
  a_answer: assert property (p_answer) else $error("command not answered");
  property p_quiet;
    !cmd_valid |=> !rsp_valid && rsp_data == 16'h0000;
  endproperty
  a_quiet: assert property (p_quiet) else $error("answer without command");
  property p_ro_write;
    cmd_valid && cmd_write && cmd_code == 8'h20 |=> rsp_valid && rsp_err;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("format write accepted");
  property p_ro_read;
    cmd_valid && !cmd_write && cmd_code == 8'h20 |=> rsp_err || rsp_data == 16'h0013;
  endproperty
  a_ro_read: assert property (p_ro_read) else $error("format read wrong");
  property p_send_read;
    cmd_valid && !cmd_write && (cmd_code == 8'h15 || cmd_code == 8'h16) |=> rsp_err;
  endproperty
  a_send_read: assert property (p_send_read) else $error("send-only read ok");
  property p_page_bad;
    cmd_valid && cmd_write && cmd_code == 8'h00
      && !(cmd_wdata[7:0] inside {8'h00, 8'h01, 8'hFF}) |=> rsp_err;
  endproperty
  a_page_bad: assert property (p_page_bad) else $error("bad channel accepted");
  // sticky: a bit may only drop one edge after a clear command
  property p_fault_keep;
    |($past(fault_flags) & ~fault_flags) |-> $past(clr);
  endproperty
  a_fault_keep: assert property (p_fault_keep) else $error("fault dropped");
  property p_warn_keep;
    |($past(warn_flags) & ~warn_flags) |-> $past(clr);
  endproperty
  a_warn_keep: assert property (p_warn_keep) else $error("warning dropped");
  property p_ref_off;
    !rail_on[0] [*3] |-> vout_ref[15:0] == 16'h0000;
  endproperty
  a_ref_off: assert property (p_ref_off) else $error("reference while off");
endmodule

bind prc_core prc_props u_props (.core_clk, .rst, .cmd_valid, .cmd_write, .cmd_code,
  .cmd_wdata, .rsp_valid, .rsp_err, .rsp_data, .rail_on, .vout_ref, .fault_flags,
  .warn_flags);

// ===== dv/prc_host.sv
/*
  host side model of the command port.
  assumes the bench calls issue from one thread only.
*/
`timescale 1ns/1ps

module prc_host (
  input wire logic core_clk,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // one-cycle strobe, launched and dropped on falling edges
  task automatic issue(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code = c;
    cmd_wdata = d;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    // idle fields inverted so stale values are never mistaken for data
    cmd_write = ~w;
    cmd_code = ~c;
    cmd_wdata = ~d;
  endtask
endmodule

// ===== dv/power_rail_command_set_test.sv
/*
  self-checking bench for the rail command decoder.
  assumes prc_host drives commands and prc_props is bound in.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end

module power_rail_command_set_test;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid, cmd_write, rsp_valid, rsp_err;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, rsp_data, v;
  logic [1:0] en_pin = 2'b11;
  logic [1:0] rail_on;
  logic [31:0] meas_vout = 32'h1F401F40;
  logic [31:0] meas_ipeak = 32'h0, meas_ivalley = 32'h0, meas_temp = 32'h0;
  logic [31:0] meas_iavg = 32'h0;
  logic [15:0] meas_vin = 16'h0000;
  logic [31:0] vout_ref, switch_rate, phase_offset, isense_gain, isense_trim;
  logic [13:0] fault_flags, warn_flags;
  logic [16:0] q[$];
  logic [16:0] exp_rsp;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  int seed = 32'h4FF3;
  int i;
  // channel, code, reset value; strap 1F40h keeps percentages exact
  logic [31:0] tbl[38] = '{
    32'h00000000, 32'h00010000, 32'h00020017, 32'h00200013, 32'h00211F40, 32'h00230000,
    32'h00242260, 32'h002520D0, 32'h00261DB0, 32'h0027BA00, 32'h00280000, 32'h00330215,
    32'h00370021, 32'h0038B2C3, 32'h0039B529, 32'h004023F0, 32'h00410080, 32'h00422260,
    32'h00431C20, 32'h00441A90, 32'h00450080, 32'h0046E320, 32'h004A0000, 32'h004BE4E0,
    32'h004FEB98, 32'h00500080, 32'h0051EB48, 32'h0052DC40, 32'h0053E530, 32'h00540080,
    32'h0055D3A0, 32'h00560080, 32'h0057D353, 32'h00580000, 32'h01370022, 32'h0138B2D7,
    32'h0139BDDC, 32'h01211F40};
  logic [7:0] fb[6] = '{8'd0, 8'd2, 8'd3, 8'd4, 8'd8, 8'd6};
  logic [7:0] rw[4] = '{8'h33, 8'h37, 8'h38, 8'h39};

  always #10 core_clk = ~core_clk;

  prc_host u_host (.core_clk, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata);

  prc_core u_dut (.core_clk, .rst, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata, .en_pin,
    .strap_vout(16'h1F40), .strap_freq(16'h0215), .meas_vout, .meas_ipeak, .meas_ivalley,
    .meas_iavg, .meas_temp, .meas_vin, .rsp_valid, .rsp_err, .rsp_data, .rail_on,
    .vout_ref, .fault_flags, .warn_flags, .switch_rate, .phase_offset, .isense_gain,
    .isense_trim);

  always @(negedge core_clk) begin
    if (rsp_valid === 1'b1) begin
      exp_rsp = q.size() ? q.pop_front() : 17'h1FFFF;
      `CHK("response", exp_rsp, {rsp_err, rsp_data})
    end
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d,
    input logic [16:0] e);
    q.push_back(e);
    u_host.issue(w, c, d);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    cmd(1'b1, c, d, 17'h0);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] d);
    cmd(1'b0, c, 16'h0000, {1'b0, d});
  endtask
  // bounded wait for the slewed reference
  task automatic wait_ref(input logic [15:0] t);
    for (int k = 0; k < 400 && vout_ref[15:0] !== t; k++) @(negedge core_clk);
  endtask
  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    foreach (tbl[k]) begin
      wr(8'h00, {8'h00, tbl[k][31:24]});
      rd(tbl[k][23:16], tbl[k][15:0]);
    end
    $display("test reset_values done");
    cmd(1'b1, 8'h20, 16'h0055, 17'h10000);
    rd(8'h20, 16'h0013);
    cmd(1'b0, 8'h15, 16'h0000, 17'h10000);
    cmd(1'b0, 8'h16, 16'h0000, 17'h10000);
    cmd(1'b0, 8'h22, 16'h0000, 17'h10000);
    cmd(1'b1, 8'h00, 16'h0005, 17'h10000);
    rd(8'h00, 16'h0001);
    $display("test refusals done");
    wr(8'h00, 16'h00FF);
    en_pin = 2'b10;
    repeat (4) @(negedge core_clk);
    `CHK("rail", 2'b10, rail_on)
    wr(8'h02, 16'h0018);
    wr(8'h01, 16'h0000);
    repeat (4) @(negedge core_clk);
    `CHK("rail", 2'b00, rail_on)
    wr(8'h01, 16'h0080);
    wr(8'h27, 16'h03FF);
    wr(8'h21, 16'h0040);
    wr(8'h23, 16'h0008);
    wait_ref(16'h0048);
    `CHK("ref", 32'h00480048, vout_ref)
    `CHK("rail", 2'b11, rail_on)
    wr(8'h24, 16'h0044);
    wait_ref(16'h0044);
    `CHK("ref", 16'h0044, vout_ref[15:0])
    wr(8'h23, 16'h0000);
    wr(8'h25, 16'h0030);
    wr(8'h01, 16'h00A0);
    wait_ref(16'h0030);
    `CHK("ref", 16'h0030, vout_ref[15:0])
    wr(8'h26, 16'h0020);
    wr(8'h01, 16'h0090);
    wait_ref(16'h0020);
    `CHK("ref", 16'h0020, vout_ref[15:0])
    $display("test rail_control done");
    v = 16'($random(seed));
    foreach (rw[k]) wr(rw[k], v);
    repeat (4) @(negedge core_clk);
    `CHK("rate", {v, v}, switch_rate)
    `CHK("phase", {v, v}, phase_offset)
    `CHK("gain", {v, v}, isense_gain)
    `CHK("trim", {v, v}, isense_trim)
    wr(8'h00, 16'h0001);
    rd(8'h38, v);
    wr(8'h16, 16'h0000);
    repeat (4) @(negedge core_clk);
    `CHK("rate", 32'h02150215, switch_rate)
    `CHK("phase", 32'h00220021, phase_offset)
    `CHK("gain", 32'hB2D7B2C3, isense_gain)
    `CHK("trim", 32'hBDDCB529, isense_trim)
    wr(8'h00, 16'h0000);
    v = 16'($random(seed));
    wr(8'h23, v);
    wr(8'h15, 16'h0000);
    wr(8'h23, ~v);
    wr(8'h16, 16'h0000);
    rd(8'h23, v);
    $display("test store_reload done");
    en_pin = 2'b11;
    for (i = 0; i < 6; i++) begin
      @(negedge core_clk);
      case (i)
        0: meas_vout[15:0] = 16'h23F1;
        1: begin
          meas_ipeak[15:0] = 16'hE321;
          meas_iavg[15:0] = 16'h0001;
        end
        2: meas_ivalley[15:0] = 16'hE4DF;
        3: meas_temp[15:0] = 16'hEB99;
        4: meas_vout[31:16] = 16'h1A8F;
        default: meas_vin = 16'hD3A1;
      endcase
      repeat (3) @(negedge core_clk);
      `CHK("fault", 1'b1, fault_flags[fb[i]])
    end
    `CHK("rail", 1'b0, rail_on[0])
    `CHK("warn", 4'hF, {warn_flags[8], warn_flags[3], warn_flags[2], warn_flags[0]})
    meas_vout = 32'h1F401F40;
    meas_ipeak = 32'h0;
    meas_iavg = 32'h0;
    meas_ivalley = 32'h0;
    meas_temp = 32'h0;
    meas_vin = 16'h0000;
    wr(8'h03, 16'h0000);
    repeat (4) @(negedge core_clk);
    `CHK("flags", 28'h0, {fault_flags, warn_flags})
    `CHK("rail", 2'b11, rail_on)
    $display("test faults done");
    repeat (4) @(negedge core_clk);
    `CHK("queue", 32'h0, q.size())
    end_sim();
  end
endmodule
